//--- fault_collection_pkg.sv
// Package with register map, reset values, states and timing constants for the fault collection unit.
package fault_collection_pkg;
  localparam int NUM_ONCHIP = 4;
  localparam int NUM_FAULTS = NUM_ONCHIP + 1;
  localparam int EXT_FAULT  = NUM_ONCHIP;
  localparam int CNT_W      = 24;
  localparam int CLK_MHZ    = 20;

  localparam logic [7:0] OFF_UNIT_CONTROL   = 8'h00;
  localparam logic [7:0] OFF_UNIT_CONFIG    = 8'h04;
  localparam logic [7:0] OFF_RECOVERY_CFG   = 8'h08;
  localparam logic [7:0] OFF_REACTION_EN    = 8'h0c;
  localparam logic [7:0] OFF_EXTRA_TIME     = 8'h10;
  localparam logic [7:0] OFF_FAULT_STATUS   = 8'h14;
  localparam logic [7:0] OFF_UNIT_STATE     = 8'h18;
  localparam logic [7:0] OFF_IRQ_STATUS     = 8'h1c;
  localparam logic [7:0] OFF_IRQ_CLEAR      = 8'h20;
  localparam logic [7:0] OFF_IRQ_ENABLE     = 8'h24;

  localparam int CTRL_OP_LSB     = 0;
  localparam int FILT_WIDTH_LSB  = 4;
  localparam int FILT_BYPASS_BIT = 8;
  localparam int CFG_PROTO_LSB   = 0;
  localparam int CFG_SAF_BIT     = 2;

  localparam logic [1:0] OP_ENTER_CONFIG = 2'h1;
  localparam logic [1:0] OP_EXIT_CONFIG  = 2'h2;

  localparam logic [1:0] PROTO_DUAL_RAIL = 2'h0;
  localparam logic [1:0] PROTO_BISTABLE  = 2'h1;

  localparam int IRQ_ALARM = 0;
  localparam int IRQ_FAULT = 1;
  localparam int IRQ_EXT   = 2;
  localparam int IRQ_W     = 3;

  localparam logic [NUM_FAULTS-1:0] RECOVERY_RST = 5'h1f;
  localparam logic [NUM_FAULTS-1:0] REACTION_RST = 5'h00;
  localparam logic [1:0]            PROTO_RST    = PROTO_DUAL_RAIL;
  localparam logic [3:0]            FILT_W_RST   = 4'h0;
  localparam logic [15:0]           EXTRA_RST    = 16'h0000;

  localparam int FAULT_PIN_US   = 250;
  localparam int FAULT_PIN_CYC  = FAULT_PIN_US * CLK_MHZ;
  localparam int ALARM_US       = 100;
  localparam int ALARM_CYC      = ALARM_US * CLK_MHZ;
  localparam int SUPERVISOR_US  = 500;
  localparam int SUPERVISOR_CYC = SUPERVISOR_US * CLK_MHZ;
  localparam int TOGGLE_US      = 10;
  localparam int TOGGLE_CYC     = TOGGLE_US * CLK_MHZ;

  typedef enum logic [1:0] {
    S_CONFIG = 2'b00,
    S_NORMAL = 2'b01,
    S_ALARM  = 2'b11,
    S_FAULT  = 2'b10
  } unit_state_t;
endpackage : fault_collection_pkg

//--- fault_collection_unit.sv
// Fault collection unit with error output signalling, output supervisor and APB registers.
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Contract
// - Per non-critical fault recovery bit; 1 means software recovery, reset default.
// - Per fault error pin reaction, each gated by its own enable bit.
// - Supervisor asserts destructive reset when unhandled fault event outlasts timeout.
// - Collection and supervision run on the safe internal RC clock.
// - CONFIG state accepts configuration; software commands exit to NORMAL.
// - Error protocol selectable, toggling or not; dual-rail after reset.
// - Set-after-reset flag, zero by default, settable only in CONFIG.
// - External input glitch filter has programmable width; bypass bit disables it.
// - Supervisor sees the external input directly, not the filtered copy.
// - Entering fault state drives pins active 250 us plus extra time.
// - Alarm cleared before timeout leaves the error pins untouched.
module fault_collection_unit #(
  parameter int FAULT_PIN_CYCLES  = fault_collection_pkg::FAULT_PIN_CYC,
  parameter int SUPERVISOR_CYCLES = fault_collection_pkg::SUPERVISOR_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  fault_in,
  input  wire logic        external_error_input,
  output logic      [1:0]  error_output_pin,
  output logic             irq,
  output logic             destructive_reset
);
  localparam int NF = fault_collection_pkg::NUM_FAULTS;
  localparam int CW = fault_collection_pkg::CNT_W;
  localparam int EX = fault_collection_pkg::EXT_FAULT;

  typedef struct packed {
    fault_collection_pkg::unit_state_t state;
    logic [NF-1:0]  recovery;
    logic [NF-1:0]  reaction_en;
    logic [NF-1:0]  fstat;
    logic [1:0]     proto;
    logic           saf;
    logic [3:0]     filt_width;
    logic           bypass;
    logic [15:0]    extra;
    logic [3:0]     fault_q;
    logic           ein_q;
    logic           ein_filt;
    logic [3:0]     filt_cnt;
    logic [CW-1:0]  timer;
    logic [CW-1:0]  sup_cnt;
    logic           sup_pend;
    logic           dreset;
    logic [CW-1:0]  tog_cnt;
    logic           tog;
    logic [1:0]     pins;
    logic [fault_collection_pkg::IRQ_W-1:0] irq_stat;
    logic [fault_collection_pkg::IRQ_W-1:0] irq_en;
    logic           irq;
    logic           ready;
    logic           err;
    logic [31:0]    rdata;
  } st_t;

  st_t st_reg;
  st_t st_next;

  // Maps an address to a register index, or 4'hf when nothing lives there.
  function automatic logic [3:0] reg_index(input logic [7:0] a);
    logic [3:0] idx;
    idx = 4'hf;
    if (a[1:0] == 2'b00 && a <= fault_collection_pkg::OFF_IRQ_ENABLE) begin
      idx = a[5:2];
    end
    return idx;
  endfunction : reg_index

  ////////////////////////////////////////////////////////////////////////////////
  logic          access;
  logic          wr_done;
  logic [3:0]    idx;
  logic          in_cfg;
  logic          handled;
  logic [NF-1:0] raw_fault;

  assign access    = psel & penable;
  assign wr_done   = access & pwrite & st_reg.ready & ~st_reg.err;
  assign idx       = reg_index(paddr);
  assign in_cfg    = st_reg.state == fault_collection_pkg::S_CONFIG;
  assign raw_fault = {st_reg.ein_filt, st_reg.fault_q};
  // The supervisor considers an event handled once the collection logic has caught it.
  assign handled   = st_reg.fstat[EX] | (st_reg.state == fault_collection_pkg::S_ALARM)
                   | (st_reg.state == fault_collection_pkg::S_FAULT);

  // Everything runs on the one clock, which is the safe RC clock of the unit.
  always_comb begin
    st_next = st_reg;
    // Bus answers one cycle into the access phase so all outputs leave flops.
    st_next.ready = access & ~st_reg.ready;
    // Error and read data stand only with pready, so a stale error never leaks on.
    st_next.err   = 1'b0;
    st_next.rdata = 32'h0000_0000;
    if (access & ~st_reg.ready) begin
      st_next.err   = idx == 4'hf;
      unique case (idx)
        4'h0: st_next.rdata = {23'h0, st_reg.bypass, st_reg.filt_width, 4'h0};
        4'h1: st_next.rdata = {29'h0, st_reg.saf, st_reg.proto};
        4'h2: st_next.rdata = {27'h0, st_reg.recovery};
        4'h3: st_next.rdata = {27'h0, st_reg.reaction_en};
        4'h4: st_next.rdata = {16'h0, st_reg.extra};
        4'h5: st_next.rdata = {27'h0, st_reg.fstat};
        4'h6: st_next.rdata = {29'h0, st_reg.dreset, st_reg.state};
        4'h7: st_next.rdata = {29'h0, st_reg.irq_stat};
        4'h9: st_next.rdata = {29'h0, st_reg.irq_en};
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end

    // Inputs are sampled once; both the collector and supervisor read this copy.
    st_next.fault_q = fault_in;
    st_next.ein_q   = external_error_input;

    // Glitch filter: a change must persist for the programmed width plus one cycles.
    if (st_reg.bypass) begin
      st_next.ein_filt = st_reg.ein_q;
      st_next.filt_cnt = 4'h0;
    end else if (st_reg.ein_q != st_reg.ein_filt) begin
      if (st_reg.filt_cnt >= st_reg.filt_width) begin
        st_next.ein_filt = st_reg.ein_q;
        st_next.filt_cnt = 4'h0;
      end else begin
        st_next.filt_cnt = st_reg.filt_cnt + 4'h1;
      end
    end else begin
      st_next.filt_cnt = 4'h0;
    end

    // Hardware recovery follows the source; software recovery stays until cleared.
    for (int i = 0; i < NF; i++) begin
      if (raw_fault[i]) begin
        st_next.fstat[i] = 1'b1;
      end else if (!st_reg.recovery[i]) begin
        st_next.fstat[i] = 1'b0;
      end else if (wr_done && idx == 4'h5 && pwdata[i]) begin
        st_next.fstat[i] = 1'b0;
      end
    end

    if (wr_done && in_cfg) begin
      unique case (idx)
        4'h0: begin
          st_next.filt_width = pwdata[fault_collection_pkg::FILT_WIDTH_LSB +: 4];
          st_next.bypass     = pwdata[fault_collection_pkg::FILT_BYPASS_BIT];
        end
        4'h1: begin
          st_next.proto = pwdata[fault_collection_pkg::CFG_PROTO_LSB +: 2];
          st_next.saf   = pwdata[fault_collection_pkg::CFG_SAF_BIT];
        end
        4'h2: st_next.recovery    = pwdata[NF-1:0];
        4'h3: st_next.reaction_en = pwdata[NF-1:0];
        4'h4: st_next.extra       = pwdata[15:0];
        default: ;
      endcase
    end

    unique case (st_reg.state)
      fault_collection_pkg::S_CONFIG: begin
        if (wr_done && idx == 4'h0
            && pwdata[1:0] == fault_collection_pkg::OP_EXIT_CONFIG) begin
          st_next.state = fault_collection_pkg::S_NORMAL;
        end
      end
      fault_collection_pkg::S_NORMAL: begin
        if (|(st_reg.fstat & st_reg.reaction_en)) begin
          st_next.state = fault_collection_pkg::S_FAULT;
          st_next.timer = CW'(FAULT_PIN_CYCLES) + CW'(st_reg.extra);
        end else if (|st_reg.fstat) begin
          st_next.state = fault_collection_pkg::S_ALARM;
          st_next.timer = CW'(fault_collection_pkg::ALARM_CYC);
        end else if (wr_done && idx == 4'h0
                     && pwdata[1:0] == fault_collection_pkg::OP_ENTER_CONFIG) begin
          st_next.state = fault_collection_pkg::S_CONFIG;
        end
      end
      fault_collection_pkg::S_ALARM: begin
        if ((|(st_reg.fstat & st_reg.reaction_en)) || st_reg.timer == '0) begin
          st_next.state = fault_collection_pkg::S_FAULT;
          st_next.timer = CW'(FAULT_PIN_CYCLES) + CW'(st_reg.extra);
        end else if (st_reg.fstat == '0) begin
          st_next.state = fault_collection_pkg::S_NORMAL;
        end else begin
          st_next.timer = st_reg.timer - CW'(1);
        end
      end
      fault_collection_pkg::S_FAULT: begin
        if (st_reg.timer != '0) begin
          st_next.timer = st_reg.timer - CW'(1);
        end else if (st_reg.fstat == '0) begin
          st_next.state = fault_collection_pkg::S_NORMAL;
        end
      end
    endcase

    // Supervisor watches the raw sampled input, bypassing the filter.
    if (st_reg.ein_q) begin
      st_next.sup_pend = 1'b1;
    end else if (handled) begin
      st_next.sup_pend = 1'b0;
    end
    if (st_reg.sup_pend && !handled) begin
      if (st_reg.sup_cnt >= CW'(SUPERVISOR_CYCLES - 1)) begin
        st_next.dreset = 1'b1;
      end else begin
        st_next.sup_cnt = st_reg.sup_cnt + CW'(1);
      end
    end else begin
      st_next.sup_cnt = '0;
    end

    if (st_reg.tog_cnt >= CW'(fault_collection_pkg::TOGGLE_CYC - 1)) begin
      st_next.tog_cnt = '0;
      st_next.tog     = ~st_reg.tog;
    end else begin
      st_next.tog_cnt = st_reg.tog_cnt + CW'(1);
    end

    // Pins only report fault in FAULT; alarm never disturbs them, config drives 00 unless the set-after-reset flag is set.
    if (in_cfg && !st_reg.saf) begin
      st_next.pins = 2'b00;
    end else if (st_reg.proto == fault_collection_pkg::PROTO_BISTABLE) begin
      st_next.pins = (st_reg.state == fault_collection_pkg::S_FAULT) ? 2'b01 : 2'b10;
    end else begin
      st_next.pins = (st_reg.state == fault_collection_pkg::S_FAULT)
                   ? 2'b00 : {st_reg.tog, ~st_reg.tog};
    end

    for (int i = 0; i < fault_collection_pkg::IRQ_W; i++) begin
      if (wr_done && idx == 4'h8 && pwdata[i]) begin
        st_next.irq_stat[i] = 1'b0;
      end
    end
    if (st_reg.state != fault_collection_pkg::S_ALARM
        && st_next.state == fault_collection_pkg::S_ALARM) begin
      st_next.irq_stat[fault_collection_pkg::IRQ_ALARM] = 1'b1;
    end
    if (st_reg.state != fault_collection_pkg::S_FAULT
        && st_next.state == fault_collection_pkg::S_FAULT) begin
      st_next.irq_stat[fault_collection_pkg::IRQ_FAULT] = 1'b1;
    end
    if (st_reg.ein_q) begin
      st_next.irq_stat[fault_collection_pkg::IRQ_EXT] = 1'b1;
    end
    if (wr_done && idx == 4'h9) begin
      st_next.irq_en = pwdata[fault_collection_pkg::IRQ_W-1:0];
    end
    st_next.irq = |(st_reg.irq_stat & st_reg.irq_en);
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_reg             <= '0;
      st_reg.state       <= fault_collection_pkg::S_CONFIG;
      st_reg.recovery    <= fault_collection_pkg::RECOVERY_RST;
      st_reg.reaction_en <= fault_collection_pkg::REACTION_RST;
      st_reg.proto       <= fault_collection_pkg::PROTO_RST;
      st_reg.saf         <= 1'b0;
      st_reg.filt_width  <= fault_collection_pkg::FILT_W_RST;
      st_reg.extra       <= fault_collection_pkg::EXTRA_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata            = st_reg.rdata;
  assign pready            = st_reg.ready;
  assign pslverr           = st_reg.err;
  assign error_output_pin  = st_reg.pins;
  assign irq               = st_reg.irq;
  assign destructive_reset = st_reg.dreset;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  property p_recovery_default;
    $fell(reset) |-> st_reg.recovery == fault_collection_pkg::RECOVERY_RST;
  endproperty
  a_recovery_default: assert property (p_recovery_default) else $error("recovery default");

  property p_reaction_fault;
    st_reg.state == fault_collection_pkg::S_NORMAL && |(st_reg.fstat & st_reg.reaction_en)
      |=> st_reg.state == fault_collection_pkg::S_FAULT ##1 st_reg.pins != 2'b10;
  endproperty
  a_reaction_fault: assert property (p_reaction_fault) else $error("no fault entry");

  property p_supervisor;
    st_reg.sup_pend && !handled && st_reg.sup_cnt == CW'(SUPERVISOR_CYCLES - 1)
      |=> destructive_reset;
  endproperty
  a_supervisor: assert property (p_supervisor) else $error("supervisor missed");

  property p_cfg_locked;
    st_reg.state != fault_collection_pkg::S_CONFIG |=> $stable(st_reg.proto)
      && $stable(st_reg.recovery) && $stable(st_reg.reaction_en);
  endproperty
  a_cfg_locked: assert property (p_cfg_locked) else $error("config changed outside");

  property p_proto_default;
    $fell(reset) |-> st_reg.proto == fault_collection_pkg::PROTO_DUAL_RAIL && !st_reg.saf;
  endproperty
  a_proto_default: assert property (p_proto_default) else $error("protocol default");

  property p_saf_config;
    $rose(st_reg.saf) |-> $past(st_reg.state) == fault_collection_pkg::S_CONFIG;
  endproperty
  a_saf_config: assert property (p_saf_config) else $error("flag set outside");

  property p_bypass;
    st_reg.bypass && st_reg.ein_q |=> st_reg.ein_filt ##1 st_reg.fstat[EX];
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass path");

  property p_direct;
    st_reg.ein_q |=> st_reg.sup_pend || handled;
  endproperty
  a_direct: assert property (p_direct) else $error("supervisor not direct");

  property p_pin_time;
    $rose(st_reg.state == fault_collection_pkg::S_FAULT)
      |-> st_reg.timer == CW'(FAULT_PIN_CYCLES) + CW'(st_reg.extra);
  endproperty
  a_pin_time: assert property (p_pin_time) else $error("fault time");

  property p_alarm_quiet;
    st_reg.state == fault_collection_pkg::S_ALARM && $past(st_reg.state)
      == fault_collection_pkg::S_ALARM
      |-> st_reg.pins != ((st_reg.proto == fault_collection_pkg::PROTO_BISTABLE)
                          ? 2'b01 : 2'b00);
  endproperty
  a_alarm_quiet: assert property (p_alarm_quiet) else $error("alarm moved pins");

  property p_short_pulse;
    st_reg.bypass && st_reg.ein_q && !destructive_reset |=> ##1 handled;
  endproperty
  a_short_pulse: assert property (p_short_pulse) else $error("pulse not caught");

  c_fault: cover property (st_reg.state == fault_collection_pkg::S_FAULT);
  c_alarm_back: cover property (st_reg.state == fault_collection_pkg::S_ALARM
    ##1 st_reg.state == fault_collection_pkg::S_NORMAL);
  c_dreset: cover property ($rose(destructive_reset));
  c_irq: cover property ($rose(irq));
endmodule : fault_collection_unit

//--- fault_collection_unit_tb.sv
// Self-checking testbench of the fault collection unit.
`timescale 1ns/100ps
module fault_collection_unit_tb;
  localparam int FPC   = 20;
  localparam int SUPC  = 50;
  localparam int LIMIT = 6000;
  logic        sys_clk, reset, psel, penable, pwrite, pready, pslverr, irq;
  logic        destructive_reset, ext_in, ext_raise, ext_ack, watch, bad_pins;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  fault_in;
  logic [1:0]  error_output_pin, p;
  logic        e;
  int          failures, n_checks, cycles, n, t0;

  fault_collection_unit #(.FAULT_PIN_CYCLES(FPC), .SUPERVISOR_CYCLES(SUPC)) u_dut (
    .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fault_in(fault_in), .external_error_input(ext_in),
    .error_output_pin(error_output_pin), .irq(irq), .destructive_reset(destructive_reset));
  fault_source_model u_src (.sys_clk(sys_clk), .ext_raise(ext_raise), .ext_ack(ext_ack),
    .fault_in(fault_in), .ext_out(ext_in));

  ////////////////////////////////////////////////////////////////////////////////
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (watch && error_output_pin !== 2'h2) bad_pins <= 1'b1;
    if (cycles == LIMIT) begin
      failures = failures + 1;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (failures == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_range(input int got, input int lo, input int hi);
    n_checks++;
    if (got < lo || got > hi) begin
      failures++;
      $display("ERROR t=%0t count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask : chk_range
  // Requests are held until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    chk({31'h0, pready}, 32'h1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask : rd_chk
  task automatic wait_pin(input logic [1:0] v);
    n = 0;
    while (error_output_pin !== v && n < 300) begin
      @(posedge sys_clk);
      n++;
    end
  endtask : wait_pin
  task automatic enter_cfg();
    wr(fault_collection_pkg::OFF_UNIT_CONTROL, {30'h0, fault_collection_pkg::OP_ENTER_CONFIG});
  endtask : enter_cfg
  task automatic exit_cfg(input logic [31:0] fields);
    wr(fault_collection_pkg::OFF_UNIT_CONTROL, fields | fault_collection_pkg::OP_EXIT_CONFIG);
  endtask : exit_cfg

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk({30'h0, error_output_pin}, 32'h0);
    rd_chk(fault_collection_pkg::OFF_RECOVERY_CFG, 32'h1f);
    rd_chk(fault_collection_pkg::OFF_REACTION_EN, 32'h0);
    rd_chk(fault_collection_pkg::OFF_UNIT_CONFIG, 32'h0);
    rd_chk(fault_collection_pkg::OFF_UNIT_STATE, 32'h0);
    apb(1'b0, 8'h28, 32'h0);
    chk({31'h0, e}, 32'h1);
  endtask : t_reset
  // Dual rail first, then the two-pass switch to the bistable protocol.
  task automatic t_proto();
    exit_cfg(32'h0);
    rd_chk(fault_collection_pkg::OFF_UNIT_STATE, 32'h1);
    p = error_output_pin;
    chk({31'h0, p[0] ^ p[1]}, 32'h1);
    wait_pin(~p);
    chk({30'h0, error_output_pin}, {30'h0, ~p});
    enter_cfg();
    wr(fault_collection_pkg::OFF_UNIT_CONFIG, 32'h1);
    exit_cfg(32'h0);
    enter_cfg();
    wr(fault_collection_pkg::OFF_UNIT_CONFIG, 32'h5);
    exit_cfg(32'h0);
    wr(fault_collection_pkg::OFF_UNIT_CONFIG, 32'h0);
    rd_chk(fault_collection_pkg::OFF_UNIT_CONFIG, 32'h5);
    chk({30'h0, error_output_pin}, 32'h2);
  endtask : t_proto
  task automatic t_fault();
    enter_cfg();
    wr(fault_collection_pkg::OFF_REACTION_EN, 32'h1);
    wr(fault_collection_pkg::OFF_EXTRA_TIME, 32'h5);
    wr(fault_collection_pkg::OFF_IRQ_ENABLE, 32'h2);
    exit_cfg(32'h0);
    u_src.pulse_fault(0, 2);
    wait_pin(2'h1);
    t0 = cycles;
    rd_chk(fault_collection_pkg::OFF_FAULT_STATUS, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(fault_collection_pkg::OFF_FAULT_STATUS, 32'h1);
    wait_pin(2'h2);
    chk_range(cycles - t0, FPC + 5, FPC + 7);
    wr(fault_collection_pkg::OFF_IRQ_CLEAR, 32'h2);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
  endtask : t_fault
  // A fault without pin reaction, cleared before the alarm runs out, leaves the pins alone.
  task automatic t_alarm();
    watch <= 1'b1;
    u_src.pulse_fault(1, 2);
    repeat (3) @(posedge sys_clk);
    rd_chk(fault_collection_pkg::OFF_UNIT_STATE, 32'h3);
    rd_chk(fault_collection_pkg::OFF_IRQ_STATUS, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(fault_collection_pkg::OFF_IRQ_ENABLE, 32'h3);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h1);
    wr(fault_collection_pkg::OFF_FAULT_STATUS, 32'h2);
    rd_chk(fault_collection_pkg::OFF_UNIT_STATE, 32'h1);
    wr(fault_collection_pkg::OFF_IRQ_CLEAR, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    watch <= 1'b0;
    chk({31'h0, bad_pins}, 32'h0);
  endtask : t_alarm
  task automatic t_ext_ok();
    enter_cfg();
    exit_cfg(32'h100);
    @(posedge sys_clk);
    ext_raise <= 1'b1;
    @(posedge sys_clk);
    ext_raise <= 1'b0;
    // Input register, filter stage and status bit each take one edge.
    repeat (2) @(posedge sys_clk);
    rd_chk(fault_collection_pkg::OFF_FAULT_STATUS, 32'h10);
    ext_ack <= 1'b1;
    @(posedge sys_clk);
    ext_ack <= 1'b0;
    wr(fault_collection_pkg::OFF_FAULT_STATUS, 32'h10);
    repeat (SUPC + 10) @(posedge sys_clk);
    chk({31'h0, destructive_reset}, 32'h0);
    rd_chk(fault_collection_pkg::OFF_UNIT_STATE, 32'h1);
  endtask : t_ext_ok
  // A short pulse slips past the wide filter but still reaches the supervisor.
  task automatic t_ext_glitch();
    enter_cfg();
    exit_cfg(32'hf0);
    @(posedge sys_clk);
    u_src.pulse_ext(3);
    n = 0;
    while (destructive_reset !== 1'b1 && n < SUPC + 20) begin
      @(posedge sys_clk);
      n++;
    end
    chk({31'h0, destructive_reset}, 32'h1);
    chk_range(n, SUPC - 8, SUPC + 6);
    rd_chk(fault_collection_pkg::OFF_FAULT_STATUS, 32'h0);
    rd_chk(fault_collection_pkg::OFF_UNIT_STATE, 32'h5);
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    chk({31'h0, destructive_reset}, 32'h0);
  endtask : t_ext_glitch

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk   = 1'b0;
    reset     = 1'b1;
    {psel, penable, pwrite, ext_raise, ext_ack, watch, bad_pins} = 7'h00;
    paddr     = 8'h00;
    pwdata    = 32'h0;
    failures  = 0;
    n_checks  = 0;
    cycles    = 0;
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    t_reset();
    t_proto();
    t_fault();
    t_alarm();
    t_ext_ok();
    t_ext_glitch();
    give_verdict();
  end
endmodule : fault_collection_unit_tb

//--- fault_source_model.sv
// Behavioural model of the on-chip fault sources and the external error source.
`timescale 1ns/100ps
module fault_source_model (
  input  wire logic       sys_clk,
  input  wire logic       ext_raise,
  input  wire logic       ext_ack,
  output logic      [3:0] fault_in,
  output logic            ext_out
);
  logic [3:0] fault_reg = 4'h0;
  logic       held_reg  = 1'b0;
  logic       pulse_reg = 1'b0;

  // Each driving block or task has its own variable so that every signal keeps a single driver.
  assign fault_in = fault_reg;
  assign ext_out  = held_reg | pulse_reg;

  // A fed-back source keeps its request up until the testbench acknowledges it on ext_ack.
  always @(posedge sys_clk) begin
    if (ext_ack) held_reg <= 1'b0;
    else if (ext_raise) held_reg <= 1'b1;
  end
  // Callers enter these right after a rising edge.
  task automatic pulse_fault(input int idx, input int len);
    fault_reg <= fault_reg | (4'h1 << idx);
    repeat (len) @(posedge sys_clk);
    fault_reg <= fault_reg & ~(4'h1 << idx);
  endtask : pulse_fault
  task automatic pulse_ext(input int len);
    pulse_reg <= 1'b1;
    repeat (len) @(posedge sys_clk);
    pulse_reg <= 1'b0;
  endtask : pulse_ext
endmodule : fault_source_model
